// file: common/pbcr_pkg.sv
// Constants and carrier types for the boot, pin status and regulator extra control registers.
// Assumes an 8-bit register port from the device's serial bus engine and a 50 MHz mclk.
// Function
// - Boot register holds power/reset config, soft-reset selector, boot delay, reserved bit.
// - Selector 1 makes soft reset restore defaults; 0 leaves registers unchanged.
// - Boot delay codes give 80, 120, 220 or 420 ms, each plus 34 ms.
// - Three-bit status reports input limit: off, 100 mA or 500 mA.
// - Four status bits show levels of two power-function and two multipurpose pins.
// - Regulator 2 discharges in hard reset; with bit set also when disabled.
// - Regulator 1 discharges in hard reset; with bit set also when disabled.
// - Regulator 1 scaling cuts FET to 20%; bit set extends it to steady on.
`default_nettype none
package pbcr_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] BOOT_CFG_ADDR  = 8'h1a;
    localparam logic [7:0] PIN_STAT_ADDR  = 8'h1b;
    localparam logic [7:0] EXTRA_CTL_ADDR = 8'h1c;
    localparam logic [7:0] UNMAPPED_DATA  = 8'h00;

    // Boot configuration fields
    localparam int BOOT_PWR_LSB   = 4;
    localparam int BOOT_SFT_BIT   = 3;
    localparam int BOOT_DLY_LSB   = 1;
    localparam int BOOT_RES_BIT   = 0;

    // Pin status fields
    localparam int PIN_ILIM_LSB   = 5;
    localparam int PIN_PFNA_BIT   = 3;
    localparam int PIN_PFNB_BIT   = 2;
    localparam int PIN_MPCB_BIT   = 1;
    localparam int PIN_MPCA_BIT   = 0;
    localparam logic [2:0] ILIM_OFF    = 3'h0;
    localparam logic [2:0] ILIM_100MA  = 3'h1;
    localparam logic [2:0] ILIM_500MA  = 3'h2;

    // Extra control fields
    localparam int EXT_R2_DSC_BIT = 6;
    localparam int EXT_R2_FET_BIT = 5;
    localparam int EXT_R1_DSC_BIT = 1;
    localparam int EXT_R1_FET_BIT = 0;
    localparam logic [7:0] EXT_WRITE_MASK = 8'h63;
    localparam logic [7:0] EXT_RESET      = 8'h00;

    // ****************************************
    // Boot delay timing
    // ****************************************
    localparam int CLK_KHZ       = 50000;
    localparam int DLY0_MS       = 80;
    localparam int DLY1_MS       = 120;
    localparam int DLY2_MS       = 220;
    localparam int DLY3_MS       = 420;
    localparam int DLY_EXTRA_MS  = 34;
    localparam int DLY0_CYCLES   = (DLY0_MS + DLY_EXTRA_MS) * CLK_KHZ;
    localparam int DLY1_CYCLES   = (DLY1_MS + DLY_EXTRA_MS) * CLK_KHZ;
    localparam int DLY2_CYCLES   = (DLY2_MS + DLY_EXTRA_MS) * CLK_KHZ;
    localparam int DLY3_CYCLES   = (DLY3_MS + DLY_EXTRA_MS) * CLK_KHZ;
    localparam int DLY_W         = 25;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [3:0] powerResetConfiguration;
        logic       softResetDefaultSelect;
        logic [1:0] bootDelaySelect;
    } pbcr_boot_s;

    typedef struct packed {
        logic powerFunctionPinALevel;
        logic powerFunctionPinBLevel;
        logic multipurposePinBLevel;
        logic multipurposePinALevel;
    } pbcr_pins_s;

    typedef struct packed {
        logic       read;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wrData;
    } pbcr_req_s;

    typedef enum logic [1:0] {BOOT_LOAD, BOOT_WAIT, BOOT_DONE} pbcr_boot_e;
endpackage
`default_nettype wire

// file: hw/pbcr_regs.sv
// Boot configuration, pin/limit status and regulator extra control register bank.
// Assumes the serial bus engine presents one-cycle read/write strobes synchronous to mclk.
`default_nettype none
module pbcr_regs import pbcr_pkg::*; #(
    parameter int DLY0 = DLY0_CYCLES,
    parameter int DLY1 = DLY1_CYCLES,
    parameter int DLY2 = DLY2_CYCLES,
    parameter int DLY3 = DLY3_CYCLES
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // Register port
    input  wire pbcr_req_s  req,
    output var  logic [7:0] rdData_r,
    // Factory straps and soft reset
    input  wire pbcr_boot_s bootStraps,
    input  wire logic       softReset,
    // Status inputs
    input  wire logic [2:0] inputLimitStatus,
    input  wire pbcr_pins_s pinLevels,
    // Regulator state
    input  wire logic       hardResetMode,
    input  wire logic       reg1Enable,
    input  wire logic       reg2Enable,
    input  wire logic       reg1TurnOn,
    input  wire logic       reg2TurnOn,
    // Regulator controls
    output var  logic       reg1Discharge_r,
    output var  logic       reg2Discharge_r,
    output var  logic       reg1FetScale_r,
    output var  logic       reg2FetScale_r,
    output var  logic       bootDone_r
);
    // ****************************************
    // Decode helper
    // ****************************************
    function automatic logic hit(input pbcr_req_s r, input logic [7:0] a);
        hit = (r.read | r.write) && (r.addr == a);
    endfunction

    // ****************************************
    // Boot straps, captured after reset release
    // ****************************************
    pbcr_boot_s boot_r, boot_nxt;
    pbcr_boot_e bst_r, bst_nxt;
    logic [DLY_W-1:0] dly_r, dly_nxt;
    logic bootDone_nxt;

    always_comb begin
        boot_nxt     = boot_r;
        bst_nxt      = bst_r;
        dly_nxt      = dly_r;
        bootDone_nxt = bootDone_r;
        unique case (bst_r)
            BOOT_LOAD: begin
                // Straps are read by a clock edge, never by the async reset
                boot_nxt = bootStraps;
                bst_nxt  = BOOT_WAIT;
                unique case (bootStraps.bootDelaySelect)
                    2'h0: dly_nxt = DLY_W'(DLY0 - 1);
                    2'h1: dly_nxt = DLY_W'(DLY1 - 1);
                    2'h2: dly_nxt = DLY_W'(DLY2 - 1);
                    2'h3: dly_nxt = DLY_W'(DLY3 - 1);
                endcase
            end
            BOOT_WAIT: begin
                if (dly_r == '0) begin
                    bst_nxt      = BOOT_DONE;
                    bootDone_nxt = 1'b1;
                end else begin
                    dly_nxt = dly_r - 1'b1;
                end
            end
            BOOT_DONE: bootDone_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            boot_r     <= '0;
            bst_r      <= BOOT_LOAD;
            dly_r      <= '0;
            bootDone_r <= 1'b0;
        end else begin
            boot_r     <= boot_nxt;
            bst_r      <= bst_nxt;
            dly_r      <= dly_nxt;
            bootDone_r <= bootDone_nxt;
        end
    end

    // ****************************************
    // Writable extra control
    // ****************************************
    logic [7:0] ext_r, ext_nxt;

    always_comb begin
        ext_nxt = ext_r;
        // soft reset restores defaults only when selected
        if (softReset && boot_r.softResetDefaultSelect) begin
            ext_nxt = EXT_RESET;
        end else if (req.write && hit(req, EXTRA_CTL_ADDR)) begin
            ext_nxt = req.wrData & EXT_WRITE_MASK;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ext_r <= EXT_RESET;
        end else begin
            ext_r <= ext_nxt;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    logic [7:0] bootByte, pinByte, rdData_nxt;

    always_comb begin
        bootByte = {boot_r.powerResetConfiguration, boot_r.softResetDefaultSelect,
                    boot_r.bootDelaySelect, 1'b0};
        pinByte = {inputLimitStatus, 1'b0, pinLevels.powerFunctionPinALevel,
                   pinLevels.powerFunctionPinBLevel, pinLevels.multipurposePinBLevel,
                   pinLevels.multipurposePinALevel};
        rdData_nxt = rdData_r;
        if (req.read) begin
            if (hit(req, BOOT_CFG_ADDR)) begin
                rdData_nxt = bootByte;
            end else if (hit(req, PIN_STAT_ADDR)) begin
                rdData_nxt = pinByte;
            end else if (hit(req, EXTRA_CTL_ADDR)) begin
                rdData_nxt = ext_r;
            end else begin
                rdData_nxt = UNMAPPED_DATA;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_r <= '0;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    // ****************************************
    // Regulator control outputs
    // ****************************************
    logic r1Dsc_nxt, r2Dsc_nxt, r1Fet_nxt, r2Fet_nxt;

    always_comb begin
        r1Dsc_nxt = hardResetMode | (ext_r[EXT_R1_DSC_BIT] & ~reg1Enable);
        r2Dsc_nxt = hardResetMode | (ext_r[EXT_R2_DSC_BIT] & ~reg2Enable);
        // regulator 1 scaling at turn-on; bit set extends it to steady on
        r1Fet_nxt = reg1TurnOn | (ext_r[EXT_R1_FET_BIT] & reg1Enable);
        r2Fet_nxt = reg2TurnOn | (ext_r[EXT_R2_FET_BIT] & reg2Enable);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg1Discharge_r <= 1'b0;
            reg2Discharge_r <= 1'b0;
            reg1FetScale_r  <= 1'b0;
            reg2FetScale_r  <= 1'b0;
        end else begin
            reg1Discharge_r <= r1Dsc_nxt;
            reg2Discharge_r <= r2Dsc_nxt;
            reg1FetScale_r  <= r1Fet_nxt;
            reg2FetScale_r  <= r2Fet_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    boot_field_pack_a: assert property (
        req.read && hit(req, BOOT_CFG_ADDR) |=> rdData_r[0] == 1'b0
            && rdData_r[7:4] == $past(boot_r.powerResetConfiguration))
        else $error("boot register packing wrong");
    soft_reset_keep_a: assert property (
        softReset && !boot_r.softResetDefaultSelect && !req.write |=> ext_r == $past(ext_r))
        else $error("soft reset changed registers");
    soft_reset_clear_a: assert property (
        softReset && boot_r.softResetDefaultSelect |=> ext_r == EXT_RESET)
        else $error("soft reset did not restore defaults");
    boot_delay_done_a: assert property (
        bst_r == BOOT_WAIT && dly_r == '0 |=> bootDone_r ##1 bootDone_r)
        else $error("boot delay end missed");
    limit_status_a: assert property (
        req.read && hit(req, PIN_STAT_ADDR) |=> rdData_r[7:5] == $past(inputLimitStatus))
        else $error("limit status wrong");
    pin_levels_a: assert property (
        req.read && hit(req, PIN_STAT_ADDR) |=> rdData_r[3:0] == $past(pinLevels))
        else $error("pin levels wrong");
    reg2_discharge_a: assert property (
        !hardResetMode && !reg2Enable && ext_r[EXT_R2_DSC_BIT] |=> reg2Discharge_r)
        else $error("regulator 2 discharge missing");
    reg1_discharge_a: assert property (
        !hardResetMode && !ext_r[EXT_R1_DSC_BIT] |=> !reg1Discharge_r)
        else $error("regulator 1 discharged outside hard reset");
    reg1_fet_scale_a: assert property (
        !reg1TurnOn && reg1Enable |=> reg1FetScale_r == $past(ext_r[EXT_R1_FET_BIT]))
        else $error("regulator 1 scaling wrong");
    reg2_fet_scale_a: assert property (
        reg2TurnOn |=> reg2FetScale_r)
        else $error("regulator 2 scaling missing at turn-on");
    reserved_zero_a: assert property (
        req.read && hit(req, EXTRA_CTL_ADDR) |=> (rdData_r & ~EXT_WRITE_MASK) == 8'h00)
        else $error("reserved bits set");
endmodule // pbcr_regs
`default_nettype wire

// file: tb/pbcr_host.sv
// Host model: single-byte register reads and writes on the strobe port.
// Assumes strobes change on falling mclk and are taken on the rising edge.
`default_nettype none
module pbcr_host import pbcr_pkg::*; (
    // Clock
    input  wire logic       mclk,
    // Register port
    output var  pbcr_req_s  req,
    input  wire logic [7:0] rdData_r
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // ****************************************
    // Accesses
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        req = '{read: 1'b0, write: 1'b1, addr: a, wrData: d};
        @(negedge mclk);
        req.write = 1'b0;
    endtask

    // Data sampled a full cycle late, clear of the update edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        req = '{read: 1'b1, write: 1'b0, addr: a, wrData: 8'h00};
        @(negedge mclk);
        req.read = 1'b0;
        @(negedge mclk);
        d = rdData_r;
    endtask
endmodule // pbcr_host
`default_nettype wire

// file: tb/pmic_boot_pin_buck_cfg_regs_tb.sv
// Self-checking bench for the boot, pin status and extra control registers.
// Assumes the host model drives the register port; short boot delays for sim.
`default_nettype none
module pmic_boot_pin_buck_cfg_regs_tb import pbcr_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY [4] = '{10, 20, 30, 40};
    logic mclk, arst_n, softReset, hardResetMode, en, turnOn, bootDone_r;
    logic dis1, dis2, fet1, fet2, b;
    logic [7:0] rdData_r, d;
    logic [2:0] inputLimitStatus;
    pbcr_req_s req;
    pbcr_boot_s bootStraps;
    pbcr_pins_s pinLevels;
    int miscompares = 0;
    int samplesChecked = 0;
    int cycles = 0;
    int n;

    pbcr_host i_pbcr_host (.mclk(mclk), .req(req), .rdData_r(rdData_r));
    pbcr_regs #(.DLY0(DLY[0]), .DLY1(DLY[1]), .DLY2(DLY[2]), .DLY3(DLY[3])) i_pbcr_regs (
        .mclk(mclk), .arst_n(arst_n), .req(req), .rdData_r(rdData_r), .bootStraps(bootStraps),
        .softReset(softReset), .inputLimitStatus(inputLimitStatus), .pinLevels(pinLevels),
        .hardResetMode(hardResetMode), .reg1Enable(en), .reg2Enable(~en), .reg1TurnOn(turnOn),
        .reg2TurnOn(turnOn), .reg1Discharge_r(dis1), .reg2Discharge_r(dis2), .reg1FetScale_r(fet1),
        .reg2FetScale_r(fet2), .bootDone_r(bootDone_r));

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {arst_n, softReset, hardResetMode, en, turnOn, inputLimitStatus, pinLevels} = '0;
        bootStraps = '0;
        // Each strap set needs its own power-on reset
        for (int i = 0; i < 4; i++) begin
            bootStraps = '{4'h5 + 4'(i), i[0], i[1:0]};
            arst_n = 1'b0;
            repeat (6) @(negedge mclk);
            arst_n = 1'b1;
            n = 0;
            while (bootDone_r !== 1'b1 && n < 100) begin
                @(posedge mclk);
                n++;
                @(negedge mclk);
            end
            chk("boot delay", 8'(DLY[i] + 1), 8'(n));
            i_pbcr_host.rd(BOOT_CFG_ADDR, d);
            chk("boot reg", {bootStraps, 1'b0}, d);
            i_pbcr_host.wr(BOOT_CFG_ADDR, 8'hff);
            i_pbcr_host.rd(BOOT_CFG_ADDR, d);
            chk("boot read-only", {bootStraps, 1'b0}, d);
            i_pbcr_host.wr(EXTRA_CTL_ADDR, 8'hff);
            softReset = 1'b1;
            @(negedge mclk);
            softReset = 1'b0;
            i_pbcr_host.rd(EXTRA_CTL_ADDR, d);
            chk("soft reset", i[0] ? 8'h00 : 8'h63, d);
        end
        $display("test boot done");
        for (int i = 0; i < 3; i++) begin
            inputLimitStatus = 3'(i);
            pinLevels = 4'(i * 5 + 3);
            repeat (2) @(negedge mclk);
            i_pbcr_host.rd(PIN_STAT_ADDR, d);
            chk("pin status", {inputLimitStatus, 1'b0, pinLevels}, d);
        end
        i_pbcr_host.wr(PIN_STAT_ADDR, 8'hff);
        i_pbcr_host.rd(PIN_STAT_ADDR, d);
        chk("status read-only", {3'h2, 1'b0, 4'hd}, d);
        i_pbcr_host.rd(8'h1d, d);
        chk("unmapped", 8'h00, d);
        $display("test status done");
        for (int k = 0; k < 16; k++) begin
            {b, en, hardResetMode, turnOn} = 4'(k);
            i_pbcr_host.wr(EXTRA_CTL_ADDR, b ? 8'hff : 8'h00);
            repeat (2) @(negedge mclk);
            chk("reg outputs", {4'h0, hardResetMode | (b & ~en), hardResetMode | (b & en),
                turnOn | (b & en), turnOn | (b & ~en)}, {4'h0, dis1, dis2, fet1, fet2});
        end
        $display("test regulator done");
        report_and_stop();
    end
endmodule // pmic_boot_pin_buck_cfg_regs_tb
`default_nettype wire
